/* hw/fwpc_top.sv */
// Function word decoder and printer output handshake with serializer.
// Assumes host inputs synchronous to core_clk_in; function word valid with its ack.
// What this block does
// - Output-enable low keeps printer and punch selection
// - Bits two and one select punch, printer
// - Input-enable low keeps input device selection
// - Bits six to four select keyboard, reader
// - Code 110 enables reader, starts read
// - Printer select sets flag, indicator, motor
// - Half second later: ready, clear, request
// - Ack latches data, drops request, starts serializer
// - Frame: space start, seven bits, mark stop
// - After character: clear register, request again
// - Print clear, master clear, deselect stop printing
// - Function ack gives 2 us select window
// - In window, print bit sets/clears flag
// - Select clear holds ready flag cleared
// - Clear register when feed, delay, transfer idle
// - Request needs clear condition and punch idle
// - Each element 9.09 ms, bit 0 first
// - No function requests while serializer busy
`timescale 1ns/1ps
module fwpc_top #(
  parameter int unsigned ELEM_CYCLES = fwpc_pkg::ELEM_CYC,
  parameter int unsigned READY_CYCLES = fwpc_pkg::READY_CYC
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [fwpc_pkg::FW_W-1:0] function_word_in,
  input wire logic function_word_ack_in,
  output logic function_word_request_out,
  input wire logic function_word_want_in,
  input wire logic [fwpc_pkg::DATA_W-1:0] output_data_in,
  input wire logic output_word_ack_in,
  output logic output_word_request_out,
  input wire logic print_clear_in,
  input wire logic master_clear_in,
  input wire logic feed_active_in,
  input wire logic feed_delay_busy_in,
  output logic print_select_out,
  output logic print_lamp_out,
  output logic printer_motor_out,
  output logic perforator_select_out,
  output logic keyboard_select_out,
  output logic reader_select_out,
  output logic read_start_out,
  output logic printer_data_out,
  output logic serializer_busy_out
);
  import fwpc_pkg::*;

  logic fw_ack_d_reg;
  logic output_word_ack_d_reg;
  logic [CNT_W-1:0] win_cnt_reg;
  logic [FW_W-1:0] fw_reg;
  logic print_select_ff;
  logic perforator_select_ff;
  logic keyboard_reg;
  logic reader_reg;
  logic read_start_reg;
  logic [CNT_W-1:0] ready_cnt_reg;
  logic printer_go_ff;
  logic print_transfer_ff;
  logic [CHAR_W-1:0] out_reg;
  fwpc_state_t state_reg;
  logic [CNT_W-1:0] elem_cnt_reg;
  logic [3:0] frame_idx_reg;
  logic [CHAR_W-1:0] shift_reg;
  logic line_reg;
  logic busy_reg;

  fwpc_buf_if wr_if ();
  fwpc_buf_if rd_if ();

  // Acknowledge rising edges, each acted on once
  wire fw_ack_edge = function_word_ack_in && !fw_ack_d_reg;
  wire output_word_ack_edge = output_word_ack_in && !output_word_ack_d_reg;
  wire window_on = (win_cnt_reg != '0);
  wire out_en = fw_reg[FW_OUT_EN];
  wire in_en = fw_reg[FW_IN_EN];
  wire [FW_IN_W-1:0] in_code = fw_reg[FW_IN_LO +: FW_IN_W];
  wire stop_print = print_clear_in || master_clear_in;
  wire printer_go_wipe = !print_select_ff;
  wire printer_go_delayed_enable = (ready_cnt_reg == CNT_W'(READY_CYCLES));
  wire clear_cond = !feed_active_in && !feed_delay_busy_in && !print_transfer_ff;
  wire out_reg_clear = clear_cond;
  wire req_raw = clear_cond && !perforator_select_ff && printer_go_ff && wr_if.ready;
  wire elem_done = (elem_cnt_reg == CNT_W'(ELEM_CYCLES - 1));

  // Window and decode
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fw_ack_d_reg <= 1'b0;
      output_word_ack_d_reg <= 1'b0;
      win_cnt_reg <= '0;
      fw_reg <= '0;
    end else begin
      fw_ack_d_reg <= function_word_ack_in;
      output_word_ack_d_reg <= output_word_ack_in;
      if (fw_ack_edge) begin
        win_cnt_reg <= CNT_W'(ACK_PULSE_CYC);
        fw_reg <= function_word_in;
      end else if (window_on) begin
        win_cnt_reg <= win_cnt_reg - CNT_W'(1);
      end
    end
  end

  // Selection flags, set only inside the window; print clear and master clear act at any time
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      print_select_ff <= 1'b0;
      perforator_select_ff <= 1'b0;
      keyboard_reg <= 1'b0;
      reader_reg <= 1'b0;
      read_start_reg <= 1'b0;
    end else begin
      read_start_reg <= 1'b0;
      if (stop_print) begin
        print_select_ff <= 1'b0;
      end else if (window_on && out_en) begin
        print_select_ff <= fw_reg[FW_PRINT];
      end
      if (master_clear_in) begin
        perforator_select_ff <= 1'b0;
        keyboard_reg <= 1'b0;
        reader_reg <= 1'b0;
      end else if (window_on) begin
        if (out_en) begin
          perforator_select_ff <= fw_reg[FW_PUNCH];
        end
        if (in_en) begin
          case (in_code)
            IN_NONE: begin
              keyboard_reg <= 1'b0;
              reader_reg <= 1'b0;
            end
            IN_KEYBOARD: begin
              keyboard_reg <= 1'b1;
              reader_reg <= 1'b0;
            end
            IN_READER: begin
              keyboard_reg <= 1'b0;
              reader_reg <= 1'b1;
            end
            IN_READ_START: begin
              keyboard_reg <= 1'b0;
              reader_reg <= 1'b1;
              read_start_reg <= fw_ack_d_reg && (win_cnt_reg == CNT_W'(ACK_PULSE_CYC));
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Half-second delay and ready flag
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ready_cnt_reg <= '0;
      printer_go_ff <= 1'b0;
    end else if (printer_go_wipe) begin
      ready_cnt_reg <= '0;
      printer_go_ff <= 1'b0;
    end else begin
      if (!printer_go_delayed_enable) begin
        ready_cnt_reg <= ready_cnt_reg + CNT_W'(1);
      end else begin
        printer_go_ff <= 1'b1;
      end
    end
  end

  // Output register: latch on ack, cleared when the clear condition holds
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      print_transfer_ff <= 1'b0;
      out_reg <= '0;
    end else if (output_word_ack_edge && output_word_request_out) begin
      print_transfer_ff <= 1'b1;
      out_reg <= output_data_in[CHAR_W-1:0];
    end else if (print_transfer_ff) begin
      print_transfer_ff <= 1'b0;
    end else if (out_reg_clear) begin
      out_reg <= '0;
    end
  end

  // Word handed to the buffer one cycle after the latch
  assign wr_if.valid = print_transfer_ff;
  assign wr_if.data = out_reg;
  assign rd_if.ready = (state_reg == FWPC_IDLE) && print_select_ff;

  fwpc_buf u_buf (
    .clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .wr(wr_if),
    .rd(rd_if)
  );

  // Serializer
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= FWPC_IDLE;
      elem_cnt_reg <= '0;
      frame_idx_reg <= '0;
      shift_reg <= '0;
      line_reg <= LINE_MARK;
      busy_reg <= 1'b0;
    end else begin
      case (state_reg)
        FWPC_IDLE: begin
          line_reg <= LINE_MARK;
          if (rd_if.valid && rd_if.ready) begin
            shift_reg <= rd_if.data;
            line_reg <= LINE_SPACE;
            elem_cnt_reg <= '0;
            frame_idx_reg <= '0;
            busy_reg <= 1'b1;
            state_reg <= FWPC_SEND;
          end
        end
        FWPC_SEND: begin
          if (!elem_done) begin
            elem_cnt_reg <= elem_cnt_reg + CNT_W'(1);
          end else begin
            elem_cnt_reg <= '0;
            frame_idx_reg <= frame_idx_reg + 4'h1;
            if (frame_idx_reg == FRAME_LAST) begin
              line_reg <= LINE_MARK;
              busy_reg <= 1'b0;
              state_reg <= FWPC_IDLE;
            end else if (frame_idx_reg == FRAME_LAST - FRAME_FIRST_DATA) begin
              line_reg <= LINE_MARK;
            end else begin
              line_reg <= shift_reg[0];
              shift_reg <= shift_reg >> 1;
            end
          end
        end
        default: begin
          state_reg <= FWPC_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // Outputs
  assign output_word_request_out = req_raw && !print_transfer_ff && !stop_print;
  assign function_word_request_out = function_word_want_in && !busy_reg;
  assign print_select_out = print_select_ff;
  assign print_lamp_out = print_select_ff;
  assign printer_motor_out = print_select_ff;
  assign perforator_select_out = perforator_select_ff;
  assign keyboard_select_out = keyboard_reg;
  assign reader_select_out = reader_reg;
  assign read_start_out = read_start_reg;
  assign printer_data_out = line_reg;
  assign serializer_busy_out = busy_reg;

  // Checks
  AST_GO_WIPE: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !print_select_ff |=> !printer_go_ff)
    else $error("Ready flag set without select");
  AST_SEL_WINDOW: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $rose(print_select_ff) |-> $past(window_on))
    else $error("Select set outside window");
  AST_NO_FW_REQ: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    busy_reg |-> !function_word_request_out)
    else $error("Function request while busy");
  AST_ACK_DROP: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    output_word_ack_edge && output_word_request_out |=> !output_word_request_out)
    else $error("Request not withdrawn on ack");
  AST_START_SPACE: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $rose(busy_reg) |-> printer_data_out == LINE_SPACE)
    else $error("Start element not space");
  AST_IDLE_MARK: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    state_reg == FWPC_IDLE && !$rose(busy_reg) && $past(state_reg) == FWPC_IDLE
    |-> printer_data_out == LINE_MARK)
    else $error("Idle line not mark");
  AST_REQ_COND: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    output_word_request_out |-> !perforator_select_ff && !feed_active_in && printer_go_ff)
    else $error("Request without enables");
  AST_STOP_CLEAR: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    print_clear_in |=> !print_select_ff)
    else $error("Print clear ignored");
  AST_KEEP_OUT: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    window_on && !out_en && !master_clear_in |=> $stable(perforator_select_ff))
    else $error("Punch changed with output disabled");
  COV_FRAME: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $fell(busy_reg));
  COV_REQ: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $rose(output_word_request_out));
  COV_READ: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
    read_start_out);
endmodule : fwpc_top

/* hw/fwpc_pkg.sv */
// Package for the function word printer control block.
// Assumes a single 200 MHz system clock.
package fwpc_pkg;
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned CLK_MHZ = 200;
  // Function word layout
  localparam int unsigned FW_W = 7;
  localparam int unsigned FW_OUT_EN = 0;
  localparam int unsigned FW_PRINT = 1;
  localparam int unsigned FW_PUNCH = 2;
  localparam int unsigned FW_IN_EN = 3;
  localparam int unsigned FW_IN_LO = 4;
  localparam int unsigned FW_IN_W = 3;
  localparam logic [2:0] IN_NONE = 3'h0;
  localparam logic [2:0] IN_KEYBOARD = 3'h1;
  localparam logic [2:0] IN_READER = 3'h2;
  localparam logic [2:0] IN_READ_START = 3'h6;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CHAR_W = 7;
  // Timing: the figure as printed, then the derived cycle count
  localparam int unsigned ACK_PULSE_US = 2;
  localparam int unsigned ACK_PULSE_CYC = ACK_PULSE_US * CLK_MHZ;
  localparam int unsigned ELEM_US = 9090;
  localparam int unsigned ELEM_CYC = ELEM_US * CLK_MHZ;
  localparam int unsigned READY_MS = 500;
  localparam int unsigned READY_CYC = READY_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 27;
  // Frame: start, seven data bits, stop
  localparam logic [3:0] FRAME_LAST = 4'h8;
  localparam logic [3:0] FRAME_FIRST_DATA = 4'h1;
  localparam logic LINE_MARK = 1'b1;
  localparam logic LINE_SPACE = 1'b0;
  typedef enum logic [1:0] {
    FWPC_IDLE = 2'b00,
    FWPC_WAIT = 2'b01,
    FWPC_SEND = 2'b11
  } fwpc_state_t;
endpackage : fwpc_pkg

/* hw/fwpc_buf_if.sv */
// Valid/ready carrier for a character between the latch and the serializer.
// Assumes both ends share core_clk_in.
`timescale 1ns/1ps
interface fwpc_buf_if;
  logic valid;
  logic ready;
  logic [fwpc_pkg::CHAR_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : fwpc_buf_if

/* hw/fwpc_buf.sv */
// Two-entry character buffer with valid/ready on both sides.
// Assumes synchronous use on one clock with async active-low reset.
`timescale 1ns/1ps
module fwpc_buf (
  input wire logic clk_in,
  input wire logic reset_n_in,
  fwpc_buf_if.snk wr,
  fwpc_buf_if.src rd
);
  import fwpc_pkg::*;
  logic [CHAR_W-1:0] mem_reg [2];
  logic wptr_reg;
  logic rptr_reg;
  logic [1:0] count_reg;
  wire push = wr.valid && wr.ready;
  wire pop = rd.valid && rd.ready;
  assign wr.ready = (count_reg != 2'h2);
  assign rd.valid = (count_reg != 2'h0);
  assign rd.data = mem_reg[rptr_reg];
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      count_reg <= 2'h0;
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
    end else begin
      if (push) begin
        mem_reg[wptr_reg] <= wr.data;
        wptr_reg <= ~wptr_reg;
      end
      if (pop) begin
        rptr_reg <= ~rptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
  AST_BUF_NO_OVER: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    count_reg == 2'h2 |-> !wr.ready)
    else $error("Buffer accepts while full");
endmodule : fwpc_buf

/* dv/fwpc_host_model.sv */
// Host side of the output word channel: offers a word, then acknowledges.
// Assumes the bench holds en_in low when no data is to be offered.
`timescale 1ns/1ps
module fwpc_host_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic en_in,
  input wire logic [7:0] delay_in,
  input wire logic [6:0] base_in,
  input wire logic request_in,
  output logic [7:0] data_out,
  output logic ack_out
);
  logic [7:0] wait_reg;
  logic [6:0] sent_reg;
  // Falling edge only, so the device samples settled values
  always_ff @(negedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_out <= 1'b0;
      data_out <= 8'h5a;
      wait_reg <= 8'h00;
      sent_reg <= 7'h00;
    end else if (ack_out) begin
      if (!request_in) begin
        ack_out <= 1'b0;
        data_out <= ~data_out;
        sent_reg <= sent_reg + 7'h01;
      end
    end else if (!en_in) begin
      wait_reg <= 8'h00;
      sent_reg <= 7'h00;
    end else if (request_in) begin
      // Word one cycle ahead of ack; top bit set to prove it is dropped
      if (wait_reg == delay_in) begin
        data_out <= {1'b1, base_in + sent_reg};
        wait_reg <= wait_reg + 8'h01;
      end else if (wait_reg > delay_in) begin
        ack_out <= 1'b1;
        wait_reg <= 8'h00;
      end else begin
        wait_reg <= wait_reg + 8'h01;
      end
    end
  end
endmodule : fwpc_host_model

/* dv/function_word_printer_control_tb.sv */
// Self-checking bench for the function word printer control block.
// Assumes short element and ready counts set through the top parameters.
`timescale 1ns/1ps
module function_word_printer_control_tb;
  localparam int unsigned ELEM = 10;
  localparam int unsigned RDY = 20;
  logic clk, reset_n, fw_ack, fw_want, oack, oreq, fwr, pclr, mclr, feed, feed_dly;
  logic ps, lamp, motor, perf, kb, rd, rs, pdata, busy, host_en;
  logic [6:0] fw;
  logic [6:0] host_base;
  logic [7:0] odata;
  logic [7:0] host_delay;
  logic ack_prev;
  int err_total, comparisons, rs_count;

  fwpc_top #(.ELEM_CYCLES(ELEM), .READY_CYCLES(RDY)) u_fwpc_top (
    .core_clk_in(clk), .reset_n_in(reset_n), .function_word_in(fw),
    .function_word_ack_in(fw_ack), .function_word_request_out(fwr),
    .function_word_want_in(fw_want), .output_data_in(odata), .output_word_ack_in(oack),
    .output_word_request_out(oreq), .print_clear_in(pclr), .master_clear_in(mclr),
    .feed_active_in(feed), .feed_delay_busy_in(feed_dly), .print_select_out(ps),
    .print_lamp_out(lamp), .printer_motor_out(motor), .perforator_select_out(perf),
    .keyboard_select_out(kb), .reader_select_out(rd), .read_start_out(rs),
    .printer_data_out(pdata), .serializer_busy_out(busy));

  fwpc_host_model u_fwpc_host_model (
    .clk_in(clk), .reset_n_in(reset_n), .en_in(host_en), .delay_in(host_delay),
    .base_in(host_base), .request_in(oreq), .data_out(odata), .ack_out(oack));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic summarize();
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic send_fw(input logic [6:0] w);
    fw = w;
    fw_ack = 1'b1;
    cyc(3);
    fw_ack = 1'b0;
    cyc(2);
  endtask : send_fw

  // Pulse counter and request withdrawal watch
  always @(negedge clk) begin
    if (rs === 1'b1) rs_count++;
    if (ack_prev === 1'b1 && oack === 1'b1) check("req_drop", 16'h0000, {15'h0, oreq});
    ack_prev = oack;
  end

  task automatic t_out_sel();
    logic [1:0] s;
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      send_fw({4'h0, s, 1'b1});
      check("out_sel", {14'h0, s}, {14'h0, perf, ps});
      check("print_ind", {14'h0, s[0], s[0]}, {14'h0, lamp, motor});
    end
    send_fw(7'h00);
    check("out_keep", 16'h0003, {14'h0, perf, ps});
    send_fw(7'h01);
    check("out_off", 16'h0000, {13'h0, perf, ps, motor});
  endtask : t_out_sel

  task automatic t_in_sel();
    logic kb_e, rd_e;
    int rs0;
    kb_e = 1'b0;
    rd_e = 1'b0;
    for (int c = 0; c < 8; c++) begin
      rs0 = rs_count;
      send_fw({3'(c), 1'b1, 3'h0});
      if (c <= 2) kb_e = (c == 1);
      if (c <= 2) rd_e = (c == 2);
      if (c == 6) {kb_e, rd_e} = 2'b01;
      check("in_sel", {14'h0, kb_e, rd_e}, {14'h0, kb, rd});
      check("read_start", {15'h0, c == 6}, 16'(rs_count - rs0));
    end
    send_fw(7'h10);
    check("in_keep", 16'h0001, {13'h0, ps, kb, rd});
  endtask : t_in_sel

  task automatic t_block();
    send_fw(7'h03);
    cyc(RDY - 8);
    check("req_early", 16'h0000, {15'h0, oreq});
    cyc(12);
    check("req_ready", 16'h0001, {15'h0, oreq});
    feed = 1'b1;
    cyc(1);
    check("req_feed", 16'h0000, {15'h0, oreq});
    feed = 1'b0;
    feed_dly = 1'b1;
    cyc(1);
    check("req_fdly", 16'h0000, {15'h0, oreq});
    feed_dly = 1'b0;
    send_fw(7'h07);
    check("req_punch", 16'h0002, {14'h0, perf, oreq});
    send_fw(7'h03);
    check("req_back", 16'h0001, {14'h0, perf, oreq});
  endtask : t_block

  task automatic t_frames(input logic [7:0] dly, input logic [6:0] base, input int n);
    logic [8:0] exp;
    logic [8:0] got;
    logic prev;
    int j;
    // Non-blocking so the host model, also on the falling edge, sees a settled value
    host_delay <= dly;
    host_base <= base;
    host_en <= 1'b1;
    for (int k = 0; k < n; k++) begin
      j = 0;
      do begin
        prev = pdata;
        cyc(1);
        j++;
      end while (!(prev === 1'b1 && pdata === 1'b0) && j < 2000);
      check("frame_found", 16'h0001, {15'h0, j < 2000});
      exp = {1'b1, 7'(base + 7'(k)), 1'b0};
      cyc(5);
      check("frame_busy", 16'h0001, {14'h0, fwr, busy});
      for (int i = 0; i < 9; i++) begin
        got[i] = pdata;
        if (i < 8) cyc(ELEM);
      end
      check("frame", {7'h0, exp}, {7'h0, got});
    end
    host_en <= 1'b0;
    cyc(5 * 9 * ELEM);
    check("idle", 16'h0007, {13'h0, busy, pdata, oreq, fwr});
  endtask : t_frames

  task automatic t_clear();
    send_fw(7'h1b);
    send_fw(7'h09);
    check("word_011", 16'h0000, {14'h0, ps, kb});
    send_fw(7'h1b);
    // Let the select window close, or it would set the flags again
    cyc(fwpc_pkg::ACK_PULSE_CYC);
    mclr = 1'b1;
    cyc(1);
    mclr = 1'b0;
    cyc(2);
    check("mclr", 16'h0000, {11'h0, ps, perf, kb, rd, oreq});
    send_fw(7'h03);
    cyc(fwpc_pkg::ACK_PULSE_CYC);
    pclr = 1'b1;
    cyc(1);
    pclr = 1'b0;
    cyc(2);
    check("pclr", 16'h0000, {14'h0, ps, oreq});
  endtask : t_clear

  initial begin
    {reset_n, fw_ack, pclr, mclr, feed, feed_dly} = 6'h00;
    host_en <= 1'b0;
    fw_want = 1'b1;
    fw = 7'h00;
    host_delay <= 8'h00;
    host_base <= 7'h00;
    cyc(5);
    reset_n = 1'b1;
    cyc(1);
    check("reset", 16'h0003, {7'h0, busy, oreq, ps, perf, kb, rd, lamp, pdata, fwr});
    t_out_sel();
    t_in_sel();
    t_block();
    t_frames(8'h00, 7'h41, 3);
    t_frames(8'h1e, 7'h3e, 2);
    t_clear();
    summarize();
  end

  // Whole run is under 3000 cycles; this allows a wide margin
  initial begin
    #100000;
    err_total++;
    summarize();
  end
endmodule : function_word_printer_control_tb
